// [shared/bsg_pkg.sv]
package bsg_pkg;

   // ----------------------------------------
   // Sizes and strap encodings
   // ----------------------------------------
   localparam int N_GPIO      = 8;   // GPIO-shared gated inputs
   localparam int N_FIXED     = 4;   // Inputs with a fixed well assignment
   localparam int PG_W        = 2;   // Width of a per-pin gating field
   localparam int PG_MSB      = 1;
   localparam int PG_LSB      = 0;

   // Values of the per-pin power well emulation field
   localparam logic [1:0] PG_VTR    = 2'h0;   // Always-on well, gated only when unselected
   localparam logic [1:0] PG_VCC    = 2'h1;   // Follows main system well
   localparam logic [1:0] PG_UNPWR  = 2'h2;   // Forced unpowered
   localparam logic [1:0] PG_RSVD   = 2'h3;

   localparam logic STRAP_ONE  = 1'b1;
   localparam logic STRAP_ZERO = 1'b0;

   // Reset value of the per-pin control fields
   localparam logic [PG_W-1:0] PG_RESET = 2'h0;

   // Boot sources, one-hot
   typedef enum logic [2:0]
   {
      BSG_BOOT_PRIVATE = 3'h1,
      BSG_BOOT_SHARED  = 3'h2,
      BSG_BOOT_ESPI    = 3'h4
   } bsg_boot_t;

   // Test access port assignment, one-hot
   typedef enum logic [1:0]
   {
      BSG_TAP_DEBUG = 2'h1,
      BSG_TAP_SCAN  = 2'h2
   } bsg_tap_t;

   // Raw strap pin levels
   typedef struct packed
   {
      logic pd_port2;
      logic pd_attached;
      logic private_flash;
      logic boot_source;
      logic scan_mode;
   } bsg_straps_t;

   // Decoded boot configuration
   typedef struct packed
   {
      logic      pd_port2_present;
      logic      pd_devices_attached;
      bsg_boot_t boot_source;
      bsg_tap_t  tap_mode;
   } bsg_config_t;

endpackage

// [logic/bsg_strap_gate.sv]
`timescale 1ns/1ps

// ----------------------------------------
// Strap capture and input gating
// ----------------------------------------
// Contract
// [R1] Gated value when well off or unselected
// [R2] Ungated inputs always follow pin
// [R3] GPIO field or fixed well per signal
// [R4] Port-2 strap: 0 absent, 1 present
// [R5] PD strap: 0 none, 1 attached
// [R6] Private strap 0 boots private SPI
// [R7] Shared strap 1 shared, 0 eSPI
// [R8] Scan strap 1 boundary, 0 debug
// [R9] Flash load only when select high
// [R10] Board holds shared select high in reset
// [R11] Straps sampled once at reset release
module bsg_strap_gate
(
   input  wire logic                                       clk,
   input  wire logic                                       resetn,
   input  wire bsg_pkg::bsg_straps_t                       strap_pins,
   input  wire logic                                       shared_flash_chip_select_n,
   input  wire logic                                       main_well_on,
   input  wire logic [bsg_pkg::N_GPIO-1:0]                  gpio_pin_in,
   input  wire logic [bsg_pkg::N_GPIO-1:0]                  gpio_mux_sel,
   input  wire logic [bsg_pkg::N_GPIO*bsg_pkg::PG_W-1:0]    power_well_emulation_select,
   input  wire logic [bsg_pkg::N_GPIO-1:0]                  gpio_gate_value,
   input  wire logic [bsg_pkg::N_GPIO-1:0]                  gpio_no_gate,
   input  wire logic [bsg_pkg::N_FIXED-1:0]                 fixed_pin_in,
   output logic [bsg_pkg::N_GPIO-1:0]                       gpio_internal,
   output logic [bsg_pkg::N_FIXED-1:0]                      fixed_internal,
   output bsg_pkg::bsg_config_t                             boot_config,
   output logic                                            straps_valid,
   output logic                                            flash_load_allowed
);

   // Fixed well assignment for non-shared signals: 1 = main well
   localparam logic [bsg_pkg::N_FIXED-1:0] FIXED_MAIN_WELL = 4'h6;
   localparam logic [bsg_pkg::N_FIXED-1:0] FIXED_GATE_VAL  = 4'h3;
   localparam logic [bsg_pkg::N_FIXED-1:0] FIXED_NO_GATE   = 4'h8;

   logic                  sampled_reg;
   bsg_pkg::bsg_straps_t  straps_reg;
   bsg_pkg::bsg_config_t  config_next;
   logic [bsg_pkg::N_GPIO-1:0]  gpio_next;
   logic [bsg_pkg::N_FIXED-1:0] fixed_next;
   logic                  flash_next;

   // ----------------------------------------
   // Strap capture
   // ----------------------------------------
   // [R11] capture once after release
   // Caught by a clocked process since an async reset may only load constants
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sampled_reg <= 1'b0;
         straps_reg  <= '0;
      end
      else if (!sampled_reg)
      begin
         sampled_reg <= 1'b1;
         straps_reg  <= strap_pins;
      end
   end

   // Decode of the held strap levels
   always_comb
   begin
      // [R4] port two presence
      config_next.pd_port2_present    = (straps_reg.pd_port2 == bsg_pkg::STRAP_ONE);
      // [R5] pd devices attached
      config_next.pd_devices_attached = (straps_reg.pd_attached == bsg_pkg::STRAP_ONE);
      // [R6] private flash select
      if (straps_reg.private_flash == bsg_pkg::STRAP_ZERO)
         config_next.boot_source = bsg_pkg::BSG_BOOT_PRIVATE;
      // [R7] shared versus eSPI
      else if (straps_reg.boot_source == bsg_pkg::STRAP_ONE)
         config_next.boot_source = bsg_pkg::BSG_BOOT_SHARED;
      else
         config_next.boot_source = bsg_pkg::BSG_BOOT_ESPI;
      // [R8] tap assignment
      config_next.tap_mode = (straps_reg.scan_mode == bsg_pkg::STRAP_ONE) ?
                             bsg_pkg::BSG_TAP_SCAN : bsg_pkg::BSG_TAP_DEBUG;
   end

   // Outputs held from flops; zero until straps valid
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         boot_config  <= '0;
         straps_valid <= 1'b0;
      end
      else
      begin
         boot_config  <= sampled_reg ? config_next : '0;
         straps_valid <= sampled_reg;
      end
   end

   // ----------------------------------------
   // Shared flash power indication
   // ----------------------------------------
   // [R9] load only when select high
   // Live level, not latched: the flash may lose power later
   assign flash_next = straps_valid && shared_flash_chip_select_n;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         flash_load_allowed <= 1'b0;
      else
         flash_load_allowed <= flash_next;
   end

   // ----------------------------------------
   // Input gating
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < bsg_pkg::N_GPIO; g++)
      begin : gen_gpio
         logic [bsg_pkg::PG_W-1:0] pg;
         logic                     well_on;
         assign pg = power_well_emulation_select[g*bsg_pkg::PG_W +: bsg_pkg::PG_W];
         // [R3] per-pin gating field
         assign well_on = (pg == bsg_pkg::PG_VTR) ||
                          ((pg == bsg_pkg::PG_VCC) && main_well_on);
         // [R1] gated when off or unselected
         // [R2] ungated follows pin
         assign gpio_next[g] = gpio_no_gate[g] ? gpio_pin_in[g] :
                               (well_on && gpio_mux_sel[g]) ? gpio_pin_in[g] :
                               gpio_gate_value[g];
      end
      for (g = 0; g < bsg_pkg::N_FIXED; g++)
      begin : gen_fixed
         logic well_on;
         // [R3] fixed per-signal well
         assign well_on = !FIXED_MAIN_WELL[g] || main_well_on;
         // [R1] gated value when off
         // [R2] ungated follows pin
         assign fixed_next[g] = (FIXED_NO_GATE[g] || well_on) ? fixed_pin_in[g] :
                                FIXED_GATE_VAL[g];
      end
   endgenerate

   // Registered to keep data outputs off combinational paths
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         gpio_internal  <= '0;
         fixed_internal <= '0;
      end
      else
      begin
         gpio_internal  <= gpio_next;
         fixed_internal <= fixed_next;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_strap_hold: assert property ( // [R11]
      @(posedge clk) disable iff (!resetn)
      straps_valid && $past(straps_valid) |-> $stable(boot_config))
      else $error("boot config changed after capture");

   a_port2_decode: assert property ( // [R4]
      @(posedge clk) disable iff (!resetn)
      straps_valid |-> boot_config.pd_port2_present == straps_reg.pd_port2)
      else $error("port two decode wrong");

   a_pd_decode: assert property ( // [R5]
      @(posedge clk) disable iff (!resetn)
      straps_valid |-> boot_config.pd_devices_attached == straps_reg.pd_attached)
      else $error("pd attached decode wrong");

   a_private_boot: assert property ( // [R6]
      @(posedge clk) disable iff (!resetn)
      straps_valid && !straps_reg.private_flash
      |-> boot_config.boot_source == bsg_pkg::BSG_BOOT_PRIVATE)
      else $error("private boot not chosen");

   a_shared_boot: assert property ( // [R7]
      @(posedge clk) disable iff (!resetn)
      straps_valid && straps_reg.private_flash
      |-> boot_config.boot_source == (straps_reg.boot_source ?
          bsg_pkg::BSG_BOOT_SHARED : bsg_pkg::BSG_BOOT_ESPI))
      else $error("shared or eSPI boot wrong");

   a_tap_mode: assert property ( // [R8]
      @(posedge clk) disable iff (!resetn)
      straps_valid |-> boot_config.tap_mode == (straps_reg.scan_mode ?
          bsg_pkg::BSG_TAP_SCAN : bsg_pkg::BSG_TAP_DEBUG))
      else $error("tap mode wrong");

   a_flash_gate: assert property ( // [R9]
      @(posedge clk) disable iff (!resetn)
      flash_load_allowed |-> $past(shared_flash_chip_select_n))
      else $error("flash load while select low");

   a_gate_value: assert property ( // [R1]
      @(posedge clk) disable iff (!resetn)
      !gpio_no_gate[0] && !gpio_mux_sel[0] |=> gpio_internal[0] == $past(gpio_gate_value[0]))
      else $error("unselected input not gated");

   a_no_gate: assert property ( // [R2]
      @(posedge clk) disable iff (!resetn)
      gpio_no_gate[0] |=> gpio_internal[0] == $past(gpio_pin_in[0]))
      else $error("ungated input not following pin");

   a_field_unpwr: assert property ( // [R3]
      @(posedge clk) disable iff (!resetn)
      !gpio_no_gate[1] && power_well_emulation_select[3:2] == bsg_pkg::PG_UNPWR
      |=> gpio_internal[1] == $past(gpio_gate_value[1]))
      else $error("unpowered field not gated");

endmodule

// [verification/bsg_board_model.sv]
`timescale 1ns/1ps

// ----------------------------------------
// Board strap resistors and flash select
// ----------------------------------------
module bsg_board_model
(
   input  wire logic                 resume_reset_n,
   input  wire bsg_pkg::bsg_straps_t strap_cfg,
   input  wire logic                 flash_powered,
   output bsg_pkg::bsg_straps_t      strap_pins,
   output logic                      shared_flash_chip_select_n
);
   // Resistors hold every strap at its fitted level
   assign strap_pins = strap_cfg;

   // select high in reset
   // Pull-up wins while resume reset is low; later the flash rail decides
   assign shared_flash_chip_select_n = !resume_reset_n | flash_powered;
endmodule

// [verification/bsg_strap_gate_tb.sv]
`timescale 1ns/1ps

module bsg_strap_gate_tb;
   logic                 clk;
   logic                 resetn;
   logic                 main_well_on;
   logic                 flash_powered;
   bsg_pkg::bsg_straps_t strap_cfg;
   bsg_pkg::bsg_straps_t strap_pins;
   logic                 sel_n;
   logic [7:0]           pin;
   logic [7:0]           mux;
   logic [7:0]           gv;
   logic [7:0]           ng;
   logic [15:0]          pwe;
   logic [3:0]           fpin;
   logic [7:0]           gpio_internal;
   logic [3:0]           fixed_internal;
   bsg_pkg::bsg_config_t boot_config;
   logic                 straps_valid;
   logic                 flash_load_allowed;
   logic [3:0]           v;
   logic [3:0]           exp_fix;
   int                   error_cnt;
   int                   num_checks;

   bsg_board_model board (.resume_reset_n(resetn), .strap_cfg(strap_cfg),
      .flash_powered(flash_powered), .strap_pins(strap_pins),
      .shared_flash_chip_select_n(sel_n));

   bsg_strap_gate dut (.clk(clk), .resetn(resetn), .strap_pins(strap_pins),
      .shared_flash_chip_select_n(sel_n), .main_well_on(main_well_on),
      .gpio_pin_in(pin), .gpio_mux_sel(mux), .power_well_emulation_select(pwe),
      .gpio_gate_value(gv), .gpio_no_gate(ng), .fixed_pin_in(fpin),
      .gpio_internal(gpio_internal), .fixed_internal(fixed_internal),
      .boot_config(boot_config), .straps_valid(straps_valid),
      .flash_load_allowed(flash_load_allowed));

   // 25 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ----------------------------------------
   // Checking helpers
   // ----------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t %s seen=%h exp=%h", $time, msg, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Decode expected from raw strap levels
   function automatic bsg_pkg::bsg_config_t exp_cfg(input bsg_pkg::bsg_straps_t s);
      bsg_pkg::bsg_config_t c;
      c.pd_port2_present    = s.pd_port2;
      c.pd_devices_attached = s.pd_attached;
      if (!s.private_flash)
         c.boot_source = bsg_pkg::BSG_BOOT_PRIVATE;
      else
         c.boot_source = s.boot_source ? bsg_pkg::BSG_BOOT_SHARED : bsg_pkg::BSG_BOOT_ESPI;
      c.tap_mode = s.scan_mode ? bsg_pkg::BSG_TAP_SCAN : bsg_pkg::BSG_TAP_DEBUG;
      return c;
   endfunction

   // Codes 2 and 3 both count as an unpowered well
   function automatic logic [7:0] exp_gpio();
      logic [7:0] r;
      logic [1:0] f;
      for (int g = 0; g < 8; g++)
      begin
         f    = pwe[2*g +: 2];
         r[g] = (ng[g] || (mux[g] && (f == 2'h0 || (f == 2'h1 && main_well_on)))) ? pin[g] : gv[g];
      end
      return r;
   endfunction

   // Reset with chosen straps, then bounded wait for capture
   task automatic reset_with(input bsg_pkg::bsg_straps_t s, input logic pwr);
      int k;
      resetn        = 1'b0;
      strap_cfg     = s;
      flash_powered = pwr;
      repeat (20) @(posedge clk);
      #1 chk(16'(boot_config), 16'h0000, "config in reset");
      resetn = 1'b1;
      k = 0;
      while (straps_valid !== 1'b1 && k < 8)
      begin
         @(posedge clk);
         #1 k++;
      end
      if (k == 8)
      begin
         error_cnt++;
         close_out();
      end
      else
         chk(16'(k), 16'h0002, "capture latency");
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      bsg_pkg::bsg_straps_t pats [4];
      pats = '{5'h13, 5'h0E, 5'h1C, 5'h05};
      error_cnt = 0;
      num_checks = 0;
      resetn = 1'b0;
      main_well_on = 1'b0;
      flash_powered = 1'b1;
      strap_cfg = 5'h00;
      {pin, mux, gv, ng, pwe, fpin} = '0;
      // Straps: every boot source and both tap modes
      for (int i = 0; i < 4; i++)
      begin
         reset_with(pats[i], i[0]);
         chk(16'(boot_config), 16'(exp_cfg(pats[i])), "strap decode");
         @(posedge clk);
         #1 chk(16'(flash_load_allowed), 16'(i[0]), "flash load");
         strap_cfg = ~pats[i];
         flash_powered = ~i[0];
         repeat (2) @(posedge clk);
         #1 chk(16'(boot_config), 16'(exp_cfg(pats[i])), "straps held");
         // Logical not: a bitwise not would widen to 16 bits before inverting
         chk(16'(flash_load_allowed), 16'(!i[0]), "flash load live");
      end
      $display("test straps done");
      // Gating: well states, mux, field codes, ungated pins
      for (int i = 0; i < 16; i++)
      begin
         v = i[3:0];
         main_well_on = v[0];
         // Bit 0 deselected in half the steps so the unselected path is reached
         mux = v[1] ? 8'hFF : 8'h5E;
         pwe = v[2] ? 16'h1B1B : 16'hE4E4;
         pin = v[3] ? 8'hA5 : 8'h3C;
         gv = ~pin;
         ng = v[3] ? 8'h81 : 8'h00;
         fpin = v ^ 4'h5;
         @(posedge clk);
         #1 chk(16'(gpio_internal), 16'(exp_gpio()), "gpio gate");
         exp_fix = main_well_on ? fpin : ((fpin & 4'h9) | 4'h2);
         chk(16'(fixed_internal), 16'(exp_fix), "fixed gate");
      end
      $display("test gating done");
      close_out();
   end
endmodule
